/* sync_fifo_core.sv */
`timescale 1ns/1ps
module sync_fifo_core (
	// system clock and reset
	input  wire logic                         mclk,
	input  wire logic                         reset,
	// write port
	input  wire logic                         writeClk,
	input  wire logic                         writeEnN,
	input  wire logic [fifo_pkg::DATA_W-1:0]  dataIn,
	// read port
	input  wire logic                         readClk,
	input  wire logic                         readEnN,
	input  wire logic                         outputEnableN,
	output logic      [fifo_pkg::DATA_W-1:0]  dataOut,
	output logic                              dataOutEn,
	// control pins
	input  wire logic                         cascade_in_or_load_pin,
	input  wire logic                         retransmit_strobe,
	// status flags, active low
	output fifo_pkg::flags_s                  flags
);

	// storage and pointers
	logic [fifo_pkg::DATA_W-1:0]  mem [int'(fifo_pkg::DEPTH)];  // word array
	logic [fifo_pkg::ADDR_W-1:0]  wrPtr_reg;                     // next write slot
	logic [fifo_pkg::ADDR_W-1:0]  rdPtr_reg;                     // next read slot
	logic [fifo_pkg::COUNT_W-1:0] count_reg;                     // unread words
	logic [fifo_pkg::COUNT_W-1:0] count_next;                    // count after this cycle
	logic                         wrapped_reg;                   // write pointer wrapped
	// outputs held in flops
	logic [fifo_pkg::DATA_W-1:0]  dataOut_reg;                   // output register
	logic                         dataOutEn_reg;                 // pin drive enable
	fifo_pkg::flags_s             flags_reg;                     // status flags
	// mode and offset programming
	fifo_pkg::mode_e              mode_reg;                      // captured mode
	logic                         modeTaken_reg;                 // mode already caught
	fifo_pkg::ofs_sel_e           ofsSel_reg;                    // next offset register
	logic [fifo_pkg::DATA_W-1:0]  ofsReg [fifo_pkg::OFS_REGS];   // offset registers
	// decoded controls
	logic                         wrEdge;                        // write clock rose
	logic                         rdEdge;                        // read clock rose
	logic                         loadActive;                    // offset access selected
	logic                         doWrite;                       // word stored this cycle
	logic                         doRead;                        // word popped this cycle
	logic                         ofsWrite;                      // offset register written
	logic                         ofsRead;                       // offset register read
	logic                         rewind;                        // retransmit accepted
	logic [fifo_pkg::OFS_W-1:0]   emptyOfs;                      // n
	logic [fifo_pkg::OFS_W-1:0]   fullOfs;                       // m
	logic [fifo_pkg::COUNT_W-1:0] rewindCount;                   // count after retransmit

	// edge detectors for both port clocks
	port_edge wrEdgeDet (
		.mclk      (mclk),
		.reset     (reset),
		.pinLevel  (writeClk),
		.risePulse (wrEdge)
	);

	port_edge rdEdgeDet (
		.mclk      (mclk),
		.reset     (reset),
		.pinLevel  (readClk),
		.risePulse (rdEdge)
	);

	// sample the strap on every edge while reset is held; the last one before
	// release counts, so a strap that follows reset itself still reads low
	always_ff @(posedge mclk) begin
		if (reset) begin
			// pin low keeps offset access, high means cascading
			mode_reg <= cascade_in_or_load_pin ? fifo_pkg::MODE_DEPTH
			                                   : fifo_pkg::MODE_STANDALONE;
		end
	end

	// offset access opens at the first edge after reset release
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			modeTaken_reg <= 1'b0;
		end else begin
			modeTaken_reg <= 1'b1;
		end
	end

	// the pin is a load enable only in standalone mode
	assign loadActive = modeTaken_reg && (mode_reg == fifo_pkg::MODE_STANDALONE)
	                    && !cascade_in_or_load_pin;

	// accepted accesses; full and empty flags gate the array
	assign doWrite  = wrEdge && !writeEnN && flags_reg.fullFlagN && !loadActive;
	assign doRead   = rdEdge && !readEnN && flags_reg.emptyFlagN && !loadActive;
	assign ofsWrite = wrEdge && !writeEnN && loadActive;
	assign ofsRead  = rdEdge && !readEnN && loadActive;

	// retransmit only when not cascaded
	assign rewind = retransmit_strobe && (mode_reg == fifo_pkg::MODE_STANDALONE);

	// the offsets as two nine-bit halves
	assign emptyOfs = {ofsReg[1], ofsReg[0]};
	assign fullOfs  = {ofsReg[3], ofsReg[2]};

	// after a rewind the span from location zero up to the write pointer is unread again, the whole array if it wrapped back to zero
	assign rewindCount = (wrapped_reg && (wrPtr_reg == '0)) ? fifo_pkg::DEPTH
	                                                         : {1'b0, wrPtr_reg};

	// next word count from both ports, rewind first
	always_comb begin
		count_next = count_reg;
		if (rewind) begin
			count_next = rewindCount;
		end else begin
			case ({doWrite, doRead})
				2'b10:   count_next = count_reg + 17'h0_0001;
				2'b01:   count_next = count_reg - 17'h0_0001;
				default: count_next = count_reg;
			endcase
		end
	end

	// write side: array store at the write pointer
	always_ff @(posedge mclk) begin
		if (doWrite) begin
			mem[wrPtr_reg] <= dataIn;
		end
	end

	// write pointer and wrap record
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wrPtr_reg   <= '0;
			wrapped_reg <= 1'b0;
		end else if (doWrite) begin
			wrPtr_reg <= wrPtr_reg + 16'h0001;
			if (wrPtr_reg == '1) begin
				wrapped_reg <= 1'b1;
			end
		end
	end

	// read pointer, rewound by retransmit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdPtr_reg <= '0;
		end else if (rewind) begin
			rdPtr_reg <= '0;
		end else if (doRead) begin
			rdPtr_reg <= rdPtr_reg + 16'h0001;
		end
	end

	// unread word count
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// output register: fifo word or offset contents, held when idle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dataOut_reg <= fifo_pkg::DATA_RESET;
		end else if (doRead) begin
			dataOut_reg <= mem[rdPtr_reg];
		end else if (ofsRead) begin
			dataOut_reg <= ofsReg[ofsSel_reg];
		end
		// blocked reads keep the last word on the outputs
	end

	// drive enable follows the output enable pin
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dataOutEn_reg <= 1'b0;
		end else begin
			dataOutEn_reg <= !outputEnableN;
		end
	end

	// offset registers, one per slot in the cycle
	genvar gi;
	generate
		for (gi = 0; gi < fifo_pkg::OFS_REGS; gi++) begin : g_ofs
			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					// low halves hold seven, high halves zero
					ofsReg[gi] <= (gi % 2 == 0) ? fifo_pkg::OFS_LOW_RESET
					                            : fifo_pkg::OFS_HIGH_RESET;
				end else if (ofsWrite && (ofsSel_reg == fifo_pkg::ofs_sel_e'(gi))) begin
					ofsReg[gi] <= dataIn;
				end
			end
		end
	endgenerate

	// shared selector; kept across load periods, wraps after four
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ofsSel_reg <= fifo_pkg::SEL_EMPTY_LOW;
		end else if (ofsWrite || ofsRead) begin
			unique case (ofsSel_reg)
				fifo_pkg::SEL_EMPTY_LOW:  ofsSel_reg <= fifo_pkg::SEL_EMPTY_HIGH;
				fifo_pkg::SEL_EMPTY_HIGH: ofsSel_reg <= fifo_pkg::SEL_FULL_LOW;
				fifo_pkg::SEL_FULL_LOW:   ofsSel_reg <= fifo_pkg::SEL_FULL_HIGH;
				fifo_pkg::SEL_FULL_HIGH:  ofsSel_reg <= fifo_pkg::SEL_EMPTY_LOW;
			endcase
		end
	end

	// status flags in one process so the struct has a single driver;
	// read side moves on read clock edges, write side on write clock edges, both on an accepted retransmit
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flags_reg <= fifo_pkg::FLAGS_RESET;
		end else begin
			if (rdEdge || rewind) begin
				flags_reg.emptyFlagN   <= (count_next != '0);
				// one flop on the read clock
				flags_reg.almostEmptyN <= ({1'b0, count_next} > emptyOfs);
			end
			if (wrEdge || rewind) begin
				flags_reg.fullFlagN   <= (count_next != fifo_pkg::DEPTH);
				// free locations above m keep it high; one flop
				flags_reg.almostFullN <=
					({1'b0, fifo_pkg::DEPTH - count_next} > fullOfs);
			end
		end
	end

	// ports come straight from flops
	assign dataOut   = dataOut_reg;
	assign dataOutEn = dataOutEn_reg;
	assign flags     = flags_reg;

	// checks next to the logic they guard

	chk_reset_empty_flags: assert property (
		@(posedge mclk) $fell(reset) |-> !flags_reg.emptyFlagN && !flags_reg.almostEmptyN
			&& flags_reg.fullFlagN && flags_reg.almostFullN && (count_reg == '0))
		else $error("flags not in empty state after reset");

	chk_reset_data_low: assert property (
		@(posedge mclk) $fell(reset) |-> (dataOut_reg == fifo_pkg::DATA_RESET))
		else $error("data outputs not low after reset");

	chk_full_blocks_write: assert property (
		@(posedge mclk) disable iff (reset)
		(wrEdge && !flags_reg.fullFlagN && !rdEdge && !rewind)
			|=> $stable(count_reg) && $stable(wrPtr_reg))
		else $error("write taken while full");

	chk_empty_holds_data: assert property (
		@(posedge mclk) disable iff (reset)
		(!flags_reg.emptyFlagN && !ofsRead) |=> $stable(dataOut_reg))
		else $error("outputs changed while empty");

	chk_full_flag_timing: assert property (
		@(posedge mclk) disable iff (reset)
		!$past(wrEdge) && !$past(rewind) |-> $stable(flags_reg.fullFlagN))
		else $error("full flag moved without write clock edge");

	chk_empty_flag_timing: assert property (
		@(posedge mclk) disable iff (reset)
		!$past(rdEdge) && !$past(rewind) |-> $stable(flags_reg.emptyFlagN))
		else $error("empty flag moved without read clock edge");

	chk_almost_empty_level: assert property (
		@(posedge mclk) disable iff (reset)
		(rdEdge && !rewind) |=>
			flags_reg.almostEmptyN == ({1'b0, count_reg} > $past(emptyOfs)))
		else $error("almost empty flag wrong after read edge");

	chk_almost_full_level: assert property (
		@(posedge mclk) disable iff (reset)
		(wrEdge && !rewind) |=>
			flags_reg.almostFullN == ({1'b0, fifo_pkg::DEPTH - count_reg} > $past(fullOfs)))
		else $error("almost full flag wrong after write edge");

	chk_rewind_pointer: assert property (
		@(posedge mclk) disable iff (reset)
		rewind |=> (rdPtr_reg == '0) && (count_reg == $past(rewindCount)))
		else $error("retransmit did not rewind read pointer");

	chk_offset_wrap: assert property (
		@(posedge mclk) disable iff (reset)
		(ofsWrite && ofsSel_reg == fifo_pkg::SEL_FULL_HIGH)
			|=> (ofsSel_reg == fifo_pkg::SEL_EMPTY_LOW) && (ofsReg[3] == $past(dataIn)))
		else $error("offset sequence did not wrap");

	chk_output_enable: assert property (
		@(posedge mclk) disable iff (reset)
		outputEnableN [*2] |-> !dataOutEn_reg)
		else $error("outputs driven while output enable high");

	chk_write_stores: assert property (
		@(posedge mclk) disable iff (reset)
		doWrite |=> (mem[$past(wrPtr_reg)] == $past(dataIn)))
		else $error("accepted write not stored");

	chk_read_presents: assert property (
		@(posedge mclk) disable iff (reset)
		doRead |=> (dataOut_reg == $past(mem[rdPtr_reg])))
		else $error("accepted read did not present the stored word");

	chk_offset_read_word: assert property (
		@(posedge mclk) disable iff (reset)
		ofsRead |=> (dataOut_reg == $past(ofsReg[ofsSel_reg])))
		else $error("offset read did not present the selected register");

	chk_load_no_store: assert property (
		@(posedge mclk) disable iff (reset)
		(loadActive && wrEdge && !rewind) |=> $stable(wrPtr_reg))
		else $error("offset load write reached the word array");

	chk_depth_ignores_rt: assert property (
		@(posedge mclk) disable iff (reset)
		(retransmit_strobe && (mode_reg == fifo_pkg::MODE_DEPTH) && !doRead)
			|=> $stable(rdPtr_reg))
		else $error("retransmit acted while cascaded");

endmodule // sync_fifo_core

/* fifo_pkg.sv */
// shared constants and carriers for the dual-port nine-bit fifo
package fifo_pkg;

	// word width and storage depth
	localparam int DATA_W  = 9;
	localparam int ADDR_W  = 16;
	localparam int COUNT_W = ADDR_W + 1;
	localparam int OFS_W   = 2 * DATA_W;

	// number of words the array holds
	localparam logic [COUNT_W-1:0] DEPTH = 17'h1_0000;

	// offset register count and reset values (n = m = 7)
	localparam int OFS_REGS = 4;
	localparam logic [DATA_W-1:0] OFS_LOW_RESET  = 9'h007;
	localparam logic [DATA_W-1:0] OFS_HIGH_RESET = 9'h000;

	// data output value while reset and before any read
	localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;

	// operating mode caught from the shared cascade/load pin
	typedef enum logic [0:0] {
		MODE_STANDALONE = 1'b0,
		MODE_DEPTH      = 1'b1
	} mode_e;

	// cyclic selection of the offset registers
	typedef enum logic [1:0] {
		SEL_EMPTY_LOW  = 2'b00,
		SEL_EMPTY_HIGH = 2'b01,
		SEL_FULL_LOW   = 2'b10,
		SEL_FULL_HIGH  = 2'b11
	} ofs_sel_e;

	// the four status flags, all active low
	typedef struct packed {
		logic fullFlagN;
		logic almostFullN;
		logic almostEmptyN;
		logic emptyFlagN;
	} flags_s;

	// flag values right after reset: empty, almost empty, not full
	localparam flags_s FLAGS_RESET = '{
		fullFlagN:    1'b1,
		almostFullN:  1'b1,
		almostEmptyN: 1'b0,
		emptyFlagN:   1'b0
	};

endpackage

/* port_edge.sv */
`timescale 1ns/1ps
// rising-edge detector for a port clock sampled on mclk
module port_edge (
	// system
	input  wire logic mclk,
	input  wire logic reset,
	// sampled port clock
	input  wire logic pinLevel,
	// one-cycle pulse on a low-to-high change
	output logic      risePulse
);

	logic prevLevel_reg;  // level seen one mclk earlier

	// remember the previous level of the port clock
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prevLevel_reg <= 1'b1;
		end else begin
			prevLevel_reg <= pinLevel;
		end
	end

	// an edge is a high now after a low before
	assign risePulse = pinLevel & ~prevLevel_reg;

endmodule // port_edge

/* fifo_port_model.sv */
`timescale 1ns/1ps
// writer and reader controllers that sit on the two port clocks of the fifo
module fifo_port_model (
	// system clock
	input  wire logic                    mclk,
	// write side
	output logic                         writeClk,
	output logic                         writeEnN,
	output logic [fifo_pkg::DATA_W-1:0]  dataIn,
	// read side
	output logic                         readClk,
	output logic                         readEnN
);
	// port clocks rest low and enables off until a transfer is asked for
	initial begin
		writeClk = 1'b0;
		writeEnN = 1'b1;
		dataIn   = 9'h000;
		readClk  = 1'b0;
		readEnN  = 1'b1;
	end

	// one write clock pulse; enable and data held over the rising edge
	task automatic push(input logic [fifo_pkg::DATA_W-1:0] d, input logic enN, input int gap);
		@(negedge mclk);
		writeEnN = enN;
		dataIn   = d;
		@(negedge mclk);
		writeClk = 1'b1;
		@(negedge mclk);
		writeClk = 1'b0;
		writeEnN = 1'b1;
		dataIn   = ~d; // a released bus must not keep showing the last word
		repeat (gap) @(negedge mclk);
	endtask

	// one read clock pulse; never overlaps a write pulse
	task automatic pop(input logic enN, input int gap);
		@(negedge mclk);
		readEnN = enN;
		@(negedge mclk);
		readClk = 1'b1;
		@(negedge mclk);
		readClk = 1'b0;
		readEnN = 1'b1;
		repeat (gap) @(negedge mclk);
	endtask
endmodule // fifo_port_model

/* tb_dual_clock_fifo_prog_flags.sv */
`timescale 1ns/1ps
// compare one design value with its expectation and count the outcome
`define CHECK_EQ(what, expv, gotv) \
	begin \
		checkCount++; \
		if ((gotv) !== (expv)) begin \
			badCount++; \
			$display("Error %s expected %h seen %h", what, expv, gotv); \
		end \
	end

module tb_dual_clock_fifo_prog_flags;
	// system
	logic                         mclk;
	logic                         reset;
	// port controls driven by the partner model
	logic                         writeClk;
	logic                         writeEnN;
	logic [fifo_pkg::DATA_W-1:0]  dataIn;
	logic                         readClk;
	logic                         readEnN;
	// pins driven by the bench
	logic                         outputEnableN;
	logic                         cascadeLoadPin;
	logic                         retransmitStrobe;
	// design outputs
	logic [fifo_pkg::DATA_W-1:0]  dataOut;
	logic                         dataOutEn;
	fifo_pkg::flags_s             flags;
	// bookkeeping
	int                           badCount = 0;
	int                           checkCount = 0;
	int                           cycleCount = 0;

	// block under test
	sync_fifo_core DUT (
		.mclk                   (mclk),
		.reset                  (reset),
		.writeClk               (writeClk),
		.writeEnN               (writeEnN),
		.dataIn                 (dataIn),
		.readClk                (readClk),
		.readEnN                (readEnN),
		.outputEnableN          (outputEnableN),
		.dataOut                (dataOut),
		.dataOutEn              (dataOutEn),
		.cascade_in_or_load_pin (cascadeLoadPin),
		.retransmit_strobe      (retransmitStrobe),
		.flags                  (flags)
	);

	// writer and reader on the far side
	fifo_port_model ctl (
		.mclk     (mclk),
		.writeClk (writeClk),
		.writeEnN (writeEnN),
		.dataIn   (dataIn),
		.readClk  (readClk),
		.readEnN  (readEnN)
	);

	// 20 ns system clock
	always #10 mclk = ~mclk;

	// cycle ceiling so that a hang still reaches the verdict
	always @(posedge mclk) begin
		cycleCount++;
		if (cycleCount == 3000) begin
			badCount++;
			$display("Error cycle limit expected %0d seen %0d", 2999, cycleCount);
			giveVerdict();
		end
	end

	// print the counts and the verdict, then stop
	task giveVerdict();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one enabled read, then compare the presented word
	task automatic readExpect(input logic [fifo_pkg::DATA_W-1:0] expv);
		ctl.pop(1'b0, 2);
		`CHECK_EQ("dataOut", expv, dataOut)
	endtask

	// reset state of flags and outputs
	task automatic resetCheck();
		`CHECK_EQ("flags", fifo_pkg::FLAGS_RESET, flags)
		`CHECK_EQ("dataOut", fifo_pkg::DATA_RESET, dataOut)
		`CHECK_EQ("dataOutEn", 1'b0, dataOutEn)
	endtask

	// offsets read back before any programming show n = m = 7
	task automatic offsetDefaults();
		logic [fifo_pkg::DATA_W-1:0] expv [4];
		expv = '{9'h007, 9'h000, 9'h007, 9'h000};
		for (int i = 0; i < 4; i++) begin
			readExpect(expv[i]);
		end
	endtask

	// five writes wrap onto the first register; a break in load resumes the order
	task automatic offsetProgram();
		logic [fifo_pkg::DATA_W-1:0] wr [5];
		logic [fifo_pkg::DATA_W-1:0] rd [4];
		wr = '{9'h005, 9'h000, 9'h1FF, 9'h07F, 9'h002};
		rd = '{9'h000, 9'h1FF, 9'h07F, 9'h002};
		for (int i = 0; i < 5; i++) begin
			ctl.push(wr[i], 1'b0, 1);
		end
		cascadeLoadPin = 1'b1;
		@(negedge mclk);
		cascadeLoadPin = 1'b0;
		for (int i = 0; i < 4; i++) begin
			readExpect(rd[i]);
		end
		cascadeLoadPin = 1'b1;
		@(negedge mclk);
	endtask

	// n = 2 and m = 65535: flag boundaries, refused write, empty hold
	task automatic dataPath();
		`CHECK_EQ("almostFullN", 1'b1, flags.almostFullN)
		ctl.push(9'h0A1, 1'b0, 2);
		`CHECK_EQ("almostFullN", 1'b0, flags.almostFullN)
		ctl.push(9'h155, 1'b1, 0);
		ctl.push(9'h0B2, 1'b0, 0);
		ctl.push(9'h0C3, 1'b0, 2);
		`CHECK_EQ("emptyFlagN", 1'b0, flags.emptyFlagN)
		ctl.pop(1'b1, 2);
		`CHECK_EQ("emptyFlagN", 1'b1, flags.emptyFlagN)
		`CHECK_EQ("almostEmptyN", 1'b1, flags.almostEmptyN)
		readExpect(9'h0A1);
		`CHECK_EQ("almostEmptyN", 1'b0, flags.almostEmptyN)
		readExpect(9'h0B2);
		readExpect(9'h0C3);
		`CHECK_EQ("emptyFlagN", 1'b0, flags.emptyFlagN)
		readExpect(9'h0C3);
	endtask

	// output enable drives and floats the data pins
	task automatic outputEnable();
		outputEnableN = 1'b0;
		repeat (2) @(negedge mclk);
		`CHECK_EQ("dataOutEn", 1'b1, dataOutEn)
		`CHECK_EQ("dataOut", 9'h0C3, dataOut)
		outputEnableN = 1'b1;
		repeat (2) @(negedge mclk);
		`CHECK_EQ("dataOutEn", 1'b0, dataOutEn)
	endtask

	// rewind with port clocks still, replay, then deliver a later write
	task automatic retransmit();
		retransmitStrobe = 1'b1;
		@(negedge mclk);
		retransmitStrobe = 1'b0;
		repeat (2) @(negedge mclk);
		`CHECK_EQ("emptyFlagN", 1'b1, flags.emptyFlagN)
		`CHECK_EQ("almostEmptyN", 1'b1, flags.almostEmptyN)
		readExpect(9'h0A1);
		ctl.push(9'h0DA, 1'b0, 0);
		readExpect(9'h0B2);
		readExpect(9'h0C3);
		readExpect(9'h0DA);
		`CHECK_EQ("emptyFlagN", 1'b0, flags.emptyFlagN)
	endtask

	// mid-run reset with the strap low only while reset is held, as when tied to reset
	task automatic strapTied();
		cascadeLoadPin = 1'b0;
		reset          = 1'b1;
		repeat (3) @(negedge mclk);
		reset          = 1'b0;
		cascadeLoadPin = 1'b1;
		@(negedge mclk);
		resetCheck();
		@(negedge mclk);
		ctl.push(9'h0E5, 1'b0, 0);
		ctl.pop(1'b1, 0);
		readExpect(9'h0E5);
		retransmitStrobe = 1'b1;
		@(negedge mclk);
		retransmitStrobe = 1'b0;
		@(negedge mclk);
		`CHECK_EQ("emptyFlagN", 1'b1, flags.emptyFlagN)
		readExpect(9'h0E5);
	endtask

	// strap high through reset selects cascading: retransmit is ignored
	task automatic depthMode();
		cascadeLoadPin = 1'b1;
		reset          = 1'b1;
		repeat (3) @(negedge mclk);
		reset          = 1'b0;
		repeat (2) @(negedge mclk);
		ctl.push(9'h0F6, 1'b0, 0);
		ctl.pop(1'b1, 0);
		readExpect(9'h0F6);
		retransmitStrobe = 1'b1;
		@(negedge mclk);
		retransmitStrobe = 1'b0;
		@(negedge mclk);
		`CHECK_EQ("emptyFlagN", 1'b0, flags.emptyFlagN)
	endtask

	// main sequence
	initial begin
		mclk             = 1'b0;
		reset            = 1'b1;
		outputEnableN    = 1'b1;
		cascadeLoadPin   = 1'b0;
		retransmitStrobe = 1'b0;
		repeat (12) @(negedge mclk);
		resetCheck();
		reset = 1'b0;
		repeat (2) @(negedge mclk);
		resetCheck();
		offsetDefaults();
		offsetProgram();
		dataPath();
		outputEnable();
		retransmit();
		strapTied();
		depthMode();
		giveVerdict();
	end
endmodule // tb_dual_clock_fifo_prog_flags
